// ### verilog/bfs_pkg.sv
// Shared constants, types and helpers for the bit, flag and shift execute block
// Assumes a 32-bit APB register bus and an 8-bit datapath
package bfs_pkg;

	localparam int          DATA_W    = 8;
	localparam int          GPR_COUNT = 32;
	localparam int          APB_AW    = 12;

	// Register byte addresses
	localparam logic [11:0] ADDR_CMD   = 12'h000;
	localparam logic [11:0] ADDR_STATUS_REGISTER  = 12'h004;
	localparam logic [11:0] ADDR_SEL   = 12'h008;
	localparam logic [11:0] ADDR_DATA  = 12'h00c;
	localparam logic [11:0] ADDR_COUNT = 12'h010;

	// Reset values
	localparam logic [7:0]  STATUS_REGISTER_RST  = 8'h00;
	localparam logic [7:0]  GPR_RST   = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// Status register bit positions
	localparam logic [2:0]  FLAG_C = 3'h0;
	localparam logic [2:0]  FLAG_Z = 3'h1;
	localparam logic [2:0]  FLAG_N = 3'h2;
	localparam logic [2:0]  FLAG_V = 3'h3;
	localparam logic [2:0]  FLAG_S = 3'h4;
	localparam logic [2:0]  FLAG_H = 3'h5;
	localparam logic [2:0]  FLAG_T = 3'h6;
	localparam logic [2:0]  FLAG_I = 3'h7;

	typedef enum logic [4:0] {
		OP_NOP,
		OP_ROTATE_RIGHT_CARRY,
		OP_ARITH_SHIFT_RIGHT,
		OP_NIBBLE_SWAP,
		OP_FLAG_FORCE_ONE,
		OP_FLAG_FORCE_ZERO,
		OP_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_BIT,
		OP_CARRY_FORCE_ONE,
		OP_CARRY_FORCE_ZERO,
		OP_NEGATIVE_FORCE_ONE,
		OP_NEGATIVE_FORCE_ZERO,
		OP_ZERO_FORCE_ONE,
		OP_ZERO_FORCE_ZERO,
		OP_IRQ_GLOBAL_ON,
		OP_IRQ_GLOBAL_OFF,
		OP_SIGN_FORCE_ONE,
		OP_SIGN_FORCE_ZERO,
		OP_OVERFLOW_FORCE_ONE,
		OP_OVERFLOW_FORCE_ZERO,
		OP_TFLAG_FORCE_ONE,
		OP_TFLAG_FORCE_ZERO,
		OP_HALF_CARRY_FORCE_ONE,
		OP_HALF_CARRY_FORCE_ZERO
	} bfs_op_t;

	localparam logic [4:0]  OP_LIMIT = 5'h18;

	// Command word: bits [4:0] op, [9:5] dst, [14:10] src, [17:15] bit index
	typedef struct packed {
		logic [2:0] bit_idx;
		logic [4:0] src;
		logic [4:0] dst;
		logic [4:0] op;
	} bfs_cmd_t;

	localparam int          CMD_W = 18;

	function automatic logic [7:0] bfs_bit_put(logic [7:0] v, logic [2:0] i, logic b);
		logic [7:0] r;
		r    = v;
		r[i] = b;
		return r;
	endfunction

endpackage

// ### verilog/bfs_shift_unit.sv
// Rotate, arithmetic shift and nibble swap on one working register value
// Purely combinational; the caller commits results on its clock edge
`timescale 1ns/1ps
module bfs_shift_unit
	import bfs_pkg::*;
(
	input  wire bfs_op_t    op,
	input  wire logic [7:0] val,
	input  wire logic [7:0] status_register,
	output logic      [7:0] res,
	output logic      [7:0] status_register_new
);

	logic cy;

	always_comb begin
		res      = val;
		cy       = status_register[FLAG_C];
		status_register_new = status_register;
		case (op)
			OP_ROTATE_RIGHT_CARRY: begin
				res = {status_register[FLAG_C], val[7:1]};
				cy  = val[0];
			end
			OP_ARITH_SHIFT_RIGHT: begin
				res = {val[7], val[7:1]};
				cy  = val[0];
			end
			OP_NIBBLE_SWAP: begin
				res = {val[3:0], val[7:4]};
			end
			default: begin
				res = val;
			end
		endcase
		// Swap leaves every flag alone
		if (op == OP_ROTATE_RIGHT_CARRY || op == OP_ARITH_SHIFT_RIGHT) begin
			status_register_new[FLAG_Z] = (res == 8'h00);
			status_register_new[FLAG_C] = cy;
			status_register_new[FLAG_N] = res[7];
			status_register_new[FLAG_V] = res[7] ^ cy;
		end
	end

endmodule

// ### verilog/bfs_flag_unit.sv
// Single status flag forcing and bit moves through the transfer flag
// Purely combinational; the caller commits results on its clock edge
`timescale 1ns/1ps
module bfs_flag_unit
	import bfs_pkg::*;
(
	input  wire bfs_op_t    op,
	input  wire logic [2:0] idx,
	input  wire logic [7:0] src_val,
	input  wire logic [7:0] dst_val,
	input  wire logic [7:0] status_register,
	output logic      [7:0] status_register_new,
	output logic      [7:0] dst_new
);

	logic       hit;
	logic [2:0] fidx;
	logic       fval;

	always_comb begin
		hit     = 1'b1;
		fidx    = idx;
		fval    = 1'b0;
		dst_new = dst_val;
		case (op)
			OP_FLAG_FORCE_ONE:        fval = 1'b1;
			OP_FLAG_FORCE_ZERO:       fval = 1'b0;
			OP_BIT_TO_TRANSFER_FLAG: begin
				fidx = FLAG_T;
				fval = src_val[idx];
			end
			OP_TRANSFER_FLAG_TO_BIT: begin
				hit     = 1'b0;
				dst_new = bfs_bit_put(dst_val, idx, status_register[FLAG_T]);
			end
			OP_CARRY_FORCE_ONE: begin
				fidx = FLAG_C;
				fval = 1'b1;
			end
			OP_CARRY_FORCE_ZERO:      fidx = FLAG_C;
			OP_NEGATIVE_FORCE_ONE: begin
				fidx = FLAG_N;
				fval = 1'b1;
			end
			OP_NEGATIVE_FORCE_ZERO:   fidx = FLAG_N;
			OP_ZERO_FORCE_ONE: begin
				fidx = FLAG_Z;
				fval = 1'b1;
			end
			OP_ZERO_FORCE_ZERO:       fidx = FLAG_Z;
			OP_IRQ_GLOBAL_ON: begin
				fidx = FLAG_I;
				fval = 1'b1;
			end
			OP_IRQ_GLOBAL_OFF:        fidx = FLAG_I;
			OP_SIGN_FORCE_ONE: begin
				fidx = FLAG_S;
				fval = 1'b1;
			end
			OP_SIGN_FORCE_ZERO:       fidx = FLAG_S;
			OP_OVERFLOW_FORCE_ONE: begin
				fidx = FLAG_V;
				fval = 1'b1;
			end
			OP_OVERFLOW_FORCE_ZERO:   fidx = FLAG_V;
			OP_TFLAG_FORCE_ONE: begin
				fidx = FLAG_T;
				fval = 1'b1;
			end
			OP_TFLAG_FORCE_ZERO:      fidx = FLAG_T;
			OP_HALF_CARRY_FORCE_ONE: begin
				fidx = FLAG_H;
				fval = 1'b1;
			end
			OP_HALF_CARRY_FORCE_ZERO: fidx = FLAG_H;
			default:                  hit  = 1'b0;
		endcase
		status_register_new = hit ? bfs_bit_put(status_register, fidx, fval) : status_register;
	end

endmodule

// ### verilog/bfs_exec_top.sv
// Execute slice for shifts, nibble swap and single flag operations
// Assumes an APB master on pclk; one command per completed write of a valid command to the command register
//
// Contract
// (RULE1) Rotate right via carry, flags Z C N V
// (RULE2) Arithmetic shift right keeps bit 7, flags
// (RULE3) Nibble swap, no flag changes, one cycle
// (RULE4) Generic flag set/clear by index operand
// (RULE5) Bit store copies source bit into T
// (RULE6) Bit load writes T into destination bit
// (RULE7) Carry force one or zero only
// (RULE8) Negative flag force one or zero only
// (RULE9) Zero flag force one or zero only
// (RULE10) Global interrupt flag on or off only
// (RULE11) Sign flag force one or zero only
// (RULE12) Overflow flag force one or zero only
// (RULE13) Transfer flag force one or zero only
// (RULE14) Half carry flag force one or zero only
// (RULE15) Flag-only ops leave working registers alone
// (RULE16) Any of 32 registers, bits 0 to 7
`timescale 1ns/1ps
module bfs_exec_top
	import bfs_pkg::*;
#(
	parameter int GPRS = GPR_COUNT
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr
);

	if (GPRS < 2 || GPRS > GPR_COUNT) begin : g_chk
		$error("GPRS must lie between 2 and 32");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0]  gpr_ff [GPRS];
	logic [7:0]  nxt_gpr [GPRS];
	logic [7:0]  status_register_ff,     nxt_status_register;
	logic [4:0]  sel_ff,      nxt_sel;
	logic [31:0] count_ff,    nxt_count;
	bfs_cmd_t    cmd_ff,      nxt_cmd;
	logic        pready_ff,   nxt_pready;
	logic [31:0] prdata_ff,   nxt_prdata;
	logic        pslverr_ff,  nxt_pslverr;

	bfs_cmd_t    wcmd;
	bfs_op_t     wop;
	logic        acc_start;
	logic        acc_done;
	logic        op_ok;
	logic        exec;
	logic        is_shift;
	logic [7:0]  dst_val;
	logic [7:0]  src_val;
	logic [7:0]  sh_res,  sh_status_register;
	logic [7:0]  fl_dst,  fl_status_register;

	assign pready  = pready_ff;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Decode of the command in the write data

	assign wcmd      = bfs_cmd_t'(pwdata[CMD_W-1:0]);
	assign wop       = bfs_op_t'(wcmd.op);
	assign op_ok     = (wcmd.op < OP_LIMIT) && (32'(wcmd.dst) < GPRS) && (32'(wcmd.src) < GPRS);
	assign acc_start = psel && penable && !pready_ff;
	assign acc_done  = psel && penable && pready_ff;
	assign exec      = acc_done && pwrite && (paddr == ADDR_CMD) && op_ok;
	assign is_shift  = (wop == OP_ROTATE_RIGHT_CARRY) || (wop == OP_ARITH_SHIFT_RIGHT)
		|| (wop == OP_NIBBLE_SWAP);
	assign dst_val   = gpr_ff[wcmd.dst]; // [RULE16]
	assign src_val   = gpr_ff[wcmd.src]; // [RULE16]

	bfs_shift_unit u_shift (
		.op       (wop),
		.val      (dst_val),
		.status_register     (status_register_ff),
		.res      (sh_res),
		.status_register_new (sh_status_register)
	);

	bfs_flag_unit u_flag (
		.op       (wop),
		.idx      (wcmd.bit_idx),
		.src_val  (src_val),
		.dst_val  (dst_val),
		.status_register     (status_register_ff),
		.status_register_new (fl_status_register),
		.dst_new  (fl_dst)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nxt_gpr     = gpr_ff;
		nxt_status_register    = status_register_ff;
		nxt_sel     = sel_ff;
		nxt_count   = count_ff;
		nxt_cmd     = cmd_ff;
		nxt_pready  = acc_start;
		nxt_prdata  = prdata_ff;
		nxt_pslverr = 1'b0;
		// Answer prepared in the first access cycle, given in the second
		if (acc_start) begin
			nxt_prdata = WORD_ZERO;
			case (paddr)
				ADDR_CMD:   nxt_prdata = {14'h0000, cmd_ff};
				ADDR_STATUS_REGISTER:  nxt_prdata = {24'h000000, status_register_ff};
				ADDR_SEL:   nxt_prdata = {27'h0000000, sel_ff};
				ADDR_DATA:  nxt_prdata = {24'h000000, gpr_ff[sel_ff]};
				ADDR_COUNT: nxt_prdata = count_ff;
				default:    nxt_pslverr = 1'b1;
			endcase
			if (pwrite && paddr == ADDR_CMD && !op_ok) begin
				nxt_pslverr = 1'b1;
			end
		end
		if (acc_done && pwrite) begin
			case (paddr)
				ADDR_STATUS_REGISTER: nxt_status_register = pwdata[7:0];
				ADDR_SEL:  nxt_sel = pwdata[4:0];
				ADDR_DATA: nxt_gpr[sel_ff] = pwdata[7:0];
				default:   nxt_sel = sel_ff;
			endcase
		end
		// Command commits at the completing edge: one cycle per operation
		if (exec) begin
			nxt_cmd   = wcmd;
			nxt_count = count_ff + 32'h0000_0001;
			if (is_shift) begin
				nxt_gpr[wcmd.dst] = sh_res;   // [RULE1] [RULE2] [RULE3]
				nxt_status_register          = sh_status_register;  // [RULE1] [RULE2] [RULE3]
			end else begin
				nxt_gpr[wcmd.dst] = fl_dst;   // [RULE6] [RULE15]
				nxt_status_register          = fl_status_register;  // [RULE4] [RULE5] [RULE7] [RULE8] [RULE9]
			end                               // [RULE10] [RULE11] [RULE12] [RULE13] [RULE14]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < GPRS; i++) begin
				gpr_ff[i] <= GPR_RST;
			end
			status_register_ff    <= STATUS_REGISTER_RST;
			sel_ff     <= 5'h00;
			count_ff   <= WORD_ZERO;
			cmd_ff     <= '0;
			pready_ff  <= 1'b0;
			prdata_ff  <= WORD_ZERO;
			pslverr_ff <= 1'b0;
		end else begin
			gpr_ff     <= nxt_gpr;
			status_register_ff    <= nxt_status_register;
			sel_ff     <= nxt_sel;
			count_ff   <= nxt_count;
			cmd_ff     <= nxt_cmd;
			pready_ff  <= nxt_pready;
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks: snapshot of the operands at each executed command

	logic       chk_vld_ff;
	bfs_cmd_t   chk_cmd_ff;
	logic [7:0] chk_dst_ff;
	logic [7:0] chk_src_ff;
	logic [7:0] chk_status_register_ff;
	bfs_op_t    cop;
	logic [7:0] cres;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_vld_ff  <= 1'b0;
			chk_cmd_ff  <= '0;
			chk_dst_ff  <= GPR_RST;
			chk_src_ff  <= GPR_RST;
			chk_status_register_ff <= STATUS_REGISTER_RST;
		end else begin
			chk_vld_ff  <= exec;
			chk_cmd_ff  <= wcmd;
			chk_dst_ff  <= dst_val;
			chk_src_ff  <= src_val;
			chk_status_register_ff <= status_register_ff;
		end
	end

	assign cop  = bfs_op_t'(chk_cmd_ff.op);
	assign cres = gpr_ff[chk_cmd_ff.dst];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_ROTATE: assert property (chk_vld_ff && cop == OP_ROTATE_RIGHT_CARRY |-> // [RULE1]
		cres == {chk_status_register_ff[FLAG_C], chk_dst_ff[7:1]} && status_register_ff[FLAG_C] == chk_dst_ff[0]
		&& status_register_ff[FLAG_V] == (cres[7] ^ chk_dst_ff[0])) else $error("rotate result wrong");
	AST_ASHIFT: assert property (chk_vld_ff && cop == OP_ARITH_SHIFT_RIGHT |-> // [RULE2]
		cres == {chk_dst_ff[7], chk_dst_ff[7:1]} && status_register_ff[FLAG_Z] == (cres == 8'h00)
		&& status_register_ff[FLAG_N] == chk_dst_ff[7]) else $error("shift result wrong");
	AST_SWAP: assert property (chk_vld_ff && cop == OP_NIBBLE_SWAP |-> // [RULE3]
		cres == {chk_dst_ff[3:0], chk_dst_ff[7:4]} && status_register_ff == chk_status_register_ff)
		else $error("swap wrong");
	AST_GENERIC_FLAG: assert property (chk_vld_ff // [RULE4]
		&& (cop == OP_FLAG_FORCE_ONE || cop == OP_FLAG_FORCE_ZERO) |-> status_register_ff
		== bfs_bit_put(chk_status_register_ff, chk_cmd_ff.bit_idx, cop == OP_FLAG_FORCE_ONE))
		else $error("generic flag op wrong");
	AST_STORE_T: assert property (chk_vld_ff && cop == OP_BIT_TO_TRANSFER_FLAG |-> // [RULE5]
		status_register_ff == bfs_bit_put(chk_status_register_ff, FLAG_T, chk_src_ff[chk_cmd_ff.bit_idx]))
		else $error("bit store wrong");
	AST_LOAD_T: assert property (chk_vld_ff && cop == OP_TRANSFER_FLAG_TO_BIT |-> // [RULE6]
		cres == bfs_bit_put(chk_dst_ff, chk_cmd_ff.bit_idx, chk_status_register_ff[FLAG_T])
		&& status_register_ff == chk_status_register_ff) else $error("bit load wrong");
	AST_CARRY: assert property (chk_vld_ff && cop == OP_CARRY_FORCE_ONE |-> // [RULE7]
		status_register_ff == (chk_status_register_ff | 8'h01)) else $error("carry set wrong");
	AST_NEG: assert property (chk_vld_ff && cop == OP_NEGATIVE_FORCE_ZERO |-> // [RULE8]
		status_register_ff == (chk_status_register_ff & 8'hfb)) else $error("negative clear wrong");
	AST_ZERO: assert property (chk_vld_ff && cop == OP_ZERO_FORCE_ONE |-> // [RULE9]
		status_register_ff == (chk_status_register_ff | 8'h02)) else $error("zero set wrong");
	AST_IRQ: assert property (chk_vld_ff && cop == OP_IRQ_GLOBAL_OFF |-> // [RULE10]
		status_register_ff == (chk_status_register_ff & 8'h7f)) else $error("irq off wrong");
	AST_SIGN: assert property (chk_vld_ff && cop == OP_SIGN_FORCE_ONE |-> // [RULE11]
		status_register_ff == (chk_status_register_ff | 8'h10)) else $error("sign set wrong");
	AST_OVF: assert property (chk_vld_ff && cop == OP_OVERFLOW_FORCE_ZERO |-> // [RULE12]
		status_register_ff == (chk_status_register_ff & 8'hf7)) else $error("overflow clear wrong");
	AST_TFLAG: assert property (chk_vld_ff && cop == OP_TFLAG_FORCE_ONE |-> // [RULE13]
		status_register_ff == (chk_status_register_ff | 8'h40)) else $error("transfer flag set wrong");
	AST_HALF: assert property (chk_vld_ff && cop == OP_HALF_CARRY_FORCE_ONE |-> // [RULE14]
		status_register_ff == (chk_status_register_ff | 8'h20)) else $error("half carry set wrong");
	AST_FLAG_ONLY: assert property (chk_vld_ff && !(cop inside {OP_ROTATE_RIGHT_CARRY, // [RULE15]
		OP_ARITH_SHIFT_RIGHT, OP_NIBBLE_SWAP, OP_TRANSFER_FLAG_TO_BIT}) |-> cres == chk_dst_ff)
		else $error("flag op touched a register");
	AST_ONE_CYCLE: assert property (exec |=> chk_vld_ff ##1 !chk_vld_ff) // [RULE3]
		else $error("command not executed in one cycle");

	////////////////////////////////////////////////////////////////////////////////
	// Checks: the opposite polarity of each dedicated flag op

	AST_CARRY_CLR: assert property (chk_vld_ff && cop == OP_CARRY_FORCE_ZERO |-> // [RULE7]
		status_register_ff == (chk_status_register_ff & 8'hfe)) else $error("carry clear wrong");
	AST_NEG_SET: assert property (chk_vld_ff && cop == OP_NEGATIVE_FORCE_ONE |-> // [RULE8]
		status_register_ff == (chk_status_register_ff | 8'h04)) else $error("negative set wrong");
	AST_ZERO_CLR: assert property (chk_vld_ff && cop == OP_ZERO_FORCE_ZERO |-> // [RULE9]
		status_register_ff == (chk_status_register_ff & 8'hfd)) else $error("zero clear wrong");
	AST_IRQ_ON: assert property (chk_vld_ff && cop == OP_IRQ_GLOBAL_ON |-> // [RULE10]
		status_register_ff == (chk_status_register_ff | 8'h80)) else $error("irq on wrong");
	AST_SIGN_CLR: assert property (chk_vld_ff && cop == OP_SIGN_FORCE_ZERO |-> // [RULE11]
		status_register_ff == (chk_status_register_ff & 8'hef)) else $error("sign clear wrong");
	AST_OVF_SET: assert property (chk_vld_ff && cop == OP_OVERFLOW_FORCE_ONE |-> // [RULE12]
		status_register_ff == (chk_status_register_ff | 8'h08)) else $error("overflow set wrong");
	AST_TFLAG_CLR: assert property (chk_vld_ff && cop == OP_TFLAG_FORCE_ZERO |-> // [RULE13]
		status_register_ff == (chk_status_register_ff & 8'hbf)) else $error("transfer flag clear wrong");
	AST_HALF_CLR: assert property (chk_vld_ff && cop == OP_HALF_CARRY_FORCE_ZERO |-> // [RULE14]
		status_register_ff == (chk_status_register_ff & 8'hdf)) else $error("half carry clear wrong");

	////////////////////////////////////////////////////////////////////////////////
	// Checks: flags of shifts, no-op and refused commands

	AST_SHIFT_KEEP: assert property (chk_vld_ff && (cop == OP_ROTATE_RIGHT_CARRY // [RULE1]
		|| cop == OP_ARITH_SHIFT_RIGHT) |-> status_register_ff[7:4] == chk_status_register_ff[7:4])
		else $error("shift touched flags outside Z C N V");
	AST_ROT_ZN: assert property (chk_vld_ff && cop == OP_ROTATE_RIGHT_CARRY |-> // [RULE1]
		status_register_ff[FLAG_Z] == (cres == 8'h00) && status_register_ff[FLAG_N] == chk_status_register_ff[FLAG_C])
		else $error("rotate Z or N wrong");
	AST_ASHIFT_CV: assert property (chk_vld_ff && cop == OP_ARITH_SHIFT_RIGHT |-> // [RULE2]
		status_register_ff[FLAG_C] == chk_dst_ff[0] && status_register_ff[FLAG_V] == (chk_dst_ff[7] ^ chk_dst_ff[0]))
		else $error("shift C or V wrong");
	AST_NOP: assert property (chk_vld_ff && cop == OP_NOP |-> // [RULE15]
		status_register_ff == chk_status_register_ff && cres == chk_dst_ff)
		else $error("no-op changed state");
	AST_BAD_CMD: assert property (acc_start && pwrite && paddr == ADDR_CMD && !op_ok |=> // [RULE16]
		pready_ff && pslverr_ff && !exec) else $error("bad command not refused");

	////////////////////////////////////////////////////////////////////////////////
	// Checks: bus answer and command counter

	AST_READY_PULSE: assert property (pready_ff |=> !pready_ff)
		else $error("pready held over one cycle");
	AST_IDLE_QUIET: assert property (!(psel && penable) |=> !pready_ff)
		else $error("pready without access phase");
	AST_ERR_WITH_READY: assert property (pslverr_ff |-> pready_ff)
		else $error("pslverr without pready");
	AST_PRDATA_HOLD: assert property (!acc_start |=> $stable(prdata_ff))
		else $error("read data changed outside an access");
	AST_COUNT: assert property (exec |=> count_ff == $past(count_ff) + 32'h0000_0001)
		else $error("count not advanced by an executed command");
	AST_COUNT_HOLD: assert property (!exec |=> $stable(count_ff))
		else $error("count changed without a command");

	COV_ROTATE: cover property (exec && wop == OP_ROTATE_RIGHT_CARRY);
	COV_LOAD:   cover property (exec && wop == OP_TRANSFER_FLAG_TO_BIT && wcmd.dst == 5'h1f);
	COV_ERR:    cover property (pslverr_ff && pready_ff);
	COV_SWAP:   cover property (exec && wop == OP_NIBBLE_SWAP);
	COV_STORE:  cover property (exec && wop == OP_BIT_TO_TRANSFER_FLAG && wcmd.bit_idx == 3'h7);

endmodule

// ### verif/tb.sv
// Self-checking bench for the bit, flag and shift execute slice
// Assumes bfs_pkg and bfs_exec_top compiled first; APB master on a 50 ns pclk
`timescale 1ns/1ps
module tb;
	import bfs_pkg::*;

	typedef struct {
		logic        rd;
		logic        err;
		logic [31:0] d;
	} bfs_exp_t;

	localparam logic [2:0] FMAP [8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I,
		FLAG_S, FLAG_V, FLAG_T, FLAG_H};

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	bfs_exp_t    exp_q [$];
	bfs_exp_t    cur;
	int          err_count;
	int          num_checks;
	int          seed;
	logic [7:0]  gpr [32];
	logic [7:0]  status_register_m;
	logic [31:0] cnt_m;

	bfs_exec_top #(.GPRS(GPR_COUNT)) bfs_exec_top_inst (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr)
	);

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB master: note expectation, then setup and hold until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic ee);
		bfs_exp_t e;
		int       n;
		e.rd  = ~w;
		e.err = ee;
		e.d   = ed;
		n     = 0;
		exp_q.push_back(e);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			$display("[ERR] pready expected 1 seen %b", pready);
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
		apb(1'b1, a, d, WORD_ZERO, ee);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic ee);
		apb(1'b0, a, WORD_ZERO, ed, ee);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reference behaviour of one executed command
	task automatic model(input logic [4:0] op, input logic [4:0] dst, input logic [4:0] src,
		input logic [2:0] ix);
		logic [7:0] v;
		logic [7:0] r;
		v = gpr[dst];
		r = v;
		case (op)
			5'h01: r = {status_register_m[FLAG_C], v[7:1]};
			5'h02: r = {v[7], v[7:1]};
			5'h03: r = {v[3:0], v[7:4]};
			5'h04: status_register_m[ix] = 1'b1;
			5'h05: status_register_m[ix] = 1'b0;
			5'h06: status_register_m[FLAG_T] = gpr[src][ix];
			5'h07: r[ix] = status_register_m[FLAG_T];
			default: begin
				if (op >= 5'h08) begin
					status_register_m[FMAP[3'(op[4:1] - 4'h4)]] = ~op[0];
				end
			end
		endcase
		if (op == 5'h01 || op == 5'h02) begin
			status_register_m[FLAG_C] = v[0];
			status_register_m[FLAG_N] = r[7];
			status_register_m[FLAG_Z] = (r == 8'h00);
			status_register_m[FLAG_V] = r[7] ^ v[0];
		end
		gpr[dst] = r;
		cnt_m    = cnt_m + 32'h1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Monitor: compare each completed transfer with the oldest note
	always @(posedge pclk) begin
		if (presetn === 1'b1 && psel && penable && pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("[ERR] completion expected none seen one");
			end else begin
				cur = exp_q.pop_front();
				num_checks++;
				if (pslverr !== cur.err) begin
					err_count++;
					$display("[ERR] pslverr expected %b seen %b", cur.err, pslverr);
				end
				if (cur.rd && prdata !== cur.d) begin
					err_count++;
					$display("[ERR] prdata expected %h seen %h", cur.d, prdata);
				end
			end
		end
	end

	task automatic summarize;
		if (err_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#(50 * 30000);
		err_count++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [4:0]  op;
		logic [4:0]  dst;
		logic [4:0]  src;
		logic [2:0]  ix;
		logic [31:0] w32;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 12'h000;
		pwdata     = 32'h0000_0000;
		presetn    = 1'b0;
		err_count  = 0;
		num_checks = 0;
		seed       = 32'hfa4c;
		status_register_m     = STATUS_REGISTER_RST;
		cnt_m      = 32'h0;
		foreach (gpr[k]) gpr[k] = GPR_RST;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_STATUS_REGISTER, {24'h0, STATUS_REGISTER_RST}, 1'b0);
		rd(ADDR_COUNT, WORD_ZERO, 1'b0);
		rd(ADDR_CMD, WORD_ZERO, 1'b0);
		rd(ADDR_DATA, {24'h0, GPR_RST}, 1'b0);
		rd(12'h014, WORD_ZERO, 1'b1);
		wr(12'h020, 32'hffff_ffff, 1'b1);
		for (int i = 0; i < 200; i++) begin
			op  = (i < 24) ? 5'(i) : 5'($unsigned($random(seed)) % 24);
			dst = 5'($random(seed));
			src = 5'($random(seed));
			ix  = 3'($random(seed));
			w32 = $random(seed);
			wr(ADDR_SEL, {27'h0, src}, 1'b0);
			wr(ADDR_DATA, w32, 1'b0);
			gpr[src] = w32[7:0];
			w32 = $random(seed);
			wr(ADDR_SEL, {27'h0, dst}, 1'b0);
			wr(ADDR_DATA, w32, 1'b0);
			gpr[dst] = w32[7:0];
			w32 = $random(seed);
			wr(ADDR_STATUS_REGISTER, w32, 1'b0);
			status_register_m = w32[7:0];
			wr(ADDR_CMD, {14'h0, ix, src, dst, op}, 1'b0);
			model(op, dst, src, ix);
			rd(ADDR_STATUS_REGISTER, {24'h0, status_register_m}, 1'b0);
			rd(ADDR_DATA, {24'h0, gpr[dst]}, 1'b0);
			if (src != dst) begin
				wr(ADDR_SEL, {27'h0, src}, 1'b0);
				rd(ADDR_DATA, {24'h0, gpr[src]}, 1'b0);
			end
			if (i % 16 == 0) begin
				rd(ADDR_COUNT, cnt_m, 1'b0);
				rd(ADDR_CMD, {14'h0, ix, src, dst, op}, 1'b0);
				rd(ADDR_SEL, {27'h0, src}, 1'b0);
			end
		end
		wr(ADDR_CMD, {27'h0, OP_LIMIT}, 1'b1);
		wr(ADDR_CMD, 32'h0000_001f, 1'b1);
		rd(ADDR_CMD, {14'h0, ix, src, dst, op}, 1'b0);
		rd(ADDR_COUNT, cnt_m, 1'b0);
		rd(ADDR_STATUS_REGISTER, {24'h0, status_register_m}, 1'b0);
		@(posedge pclk);
		if (exp_q.size() != 0) begin
			err_count++;
			$display("[ERR] pending notes expected 0 seen %0d", exp_q.size());
		end
		summarize();
	end

endmodule
